// ==== rtl/exec_pkg.sv ====
// Purpose: shared constants for the call / clear / watchdog-clear execution block
// Assumes: 8-bit data path, 11-bit program counter
// Notes:   opcode encodings are abstract command codes, not the real instruction bits
package exec_pkg;
  localparam int PC_W   = 11;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int OP_W   = 3;

  // ---------------------------------------------------------------
  // command codes presented by decode
  // ---------------------------------------------------------------
  localparam logic [OP_W-1:0] OP_NONE   = 3'h0;
  localparam logic [OP_W-1:0] OP_CALL   = 3'h1;
  localparam logic [OP_W-1:0] OP_BYTECL = 3'h2;
  localparam logic [OP_W-1:0] OP_BITCL  = 3'h3;
  localparam logic [OP_W-1:0] OP_WDCLR  = 3'h4;
  localparam logic [OP_W-1:0] OP_WDCLR1 = 3'h5;
  localparam logic [OP_W-1:0] OP_WDCLR2 = 3'h6;

  // ---------------------------------------------------------------
  // constants and reset values
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0]   PC_STEP      = 11'h001;
  localparam logic [PC_W-1:0]   PC_RESET     = 11'h000;
  localparam logic [DATA_W-1:0] BYTE_CLEARED = 8'h00;
  localparam logic              FLAG_RESET   = 1'b0;
  localparam int                CALL_CYCLES  = 2;

  // pairing tracker: which half of the pair last ran
  typedef enum logic [2:0] {
    PAIR_NONE  = 3'b001,
    PAIR_FIRST = 3'b010,
    PAIR_SECND = 3'b100
  } pair_state_e;
endpackage

// ==== rtl/paired_clear_tracker.sv ====
// Purpose: decides whether a paired watchdog clear takes effect
// Assumes: one strobe per executed paired clear
// Notes:   the single clear does not disturb the pairing history
`timescale 1ns/1ps
module paired_clear_tracker (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic first_paired_watchdog_clear,
  input  wire logic second_paired_watchdog_clear,
  output logic      pair_fire
);
  exec_pkg::pair_state_e state;
  exec_pkg::pair_state_e next_state;

  // ---------------------------------------------------------------
  // alternation check
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    pair_fire  = 1'b0;
    case (state)
      exec_pkg::PAIR_NONE: begin
        if (first_paired_watchdog_clear) begin
          next_state = exec_pkg::PAIR_FIRST;
        end else if (second_paired_watchdog_clear) begin
          next_state = exec_pkg::PAIR_SECND;
        end
      end
      exec_pkg::PAIR_FIRST: begin
        if (second_paired_watchdog_clear) begin
          pair_fire  = 1'b1;
          next_state = exec_pkg::PAIR_SECND;
        end
        // repeated first half leaves state alone, no effect
      end
      exec_pkg::PAIR_SECND: begin
        if (first_paired_watchdog_clear) begin
          pair_fire  = 1'b1;
          next_state = exec_pkg::PAIR_FIRST;
        end
      end
      default: begin
        next_state = exec_pkg::PAIR_NONE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= exec_pkg::PAIR_NONE;
    end else begin
      state <= next_state;
    end
  end
endmodule

// ==== rtl/call_clear_watchdog_exec.sv ====
// What this block does
// - call pushes program counter plus one onto the return stack
// - call is unconditional, loads target into counter, flags untouched
// - call occupies two instruction cycles
// - byte clear writes zero to the addressed data byte
// - bit clear zeroes only the selected bit, others kept
// - single watchdog clear resets counter, timeout and power-down flags
// - first paired clear acts only after the second paired clear
// - second paired clear acts only after the first paired clear
// - repeating one paired clear alone has no effect
//
// Purpose: executes call, byte/bit clear and the three watchdog clears
// Assumes: decode presents one command per cycle with op_valid; read data of the
//          addressed byte is valid in the command cycle
// Notes:   busy holds decode off during the second call cycle
`timescale 1ns/1ps
module call_clear_watchdog_exec (
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire logic                        op_valid,
  input  wire logic [exec_pkg::OP_W-1:0]   op_code,
  input  wire logic [exec_pkg::PC_W-1:0]   cur_pc,
  input  wire logic [exec_pkg::PC_W-1:0]   call_target,
  input  wire logic [exec_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic [2:0]                  bit_sel,
  input  wire logic [exec_pkg::DATA_W-1:0] mem_rdata,
  input  wire logic                        timeout_set,
  input  wire logic                        powerdown_set,
  output logic                             busy,
  output logic                             stack_push,
  output logic [exec_pkg::PC_W-1:0]        stack_data,
  output logic                             pc_load,
  output logic [exec_pkg::PC_W-1:0]        pc_value,
  output logic                             mem_we,
  output logic [exec_pkg::ADDR_W-1:0]      mem_waddr,
  output logic [exec_pkg::DATA_W-1:0]      mem_wdata,
  output logic                             watchdog_counter_clear,
  output logic                             timeout_flag,
  output logic                             powerdown_flag
);
  // ---------------------------------------------------------------
  // command strobes
  // ---------------------------------------------------------------
  logic take;
  logic is_call;
  logic is_byte;
  logic is_bit;
  logic is_wd;
  logic is_wd1;
  logic is_wd2;
  logic pair_fire;
  logic wd_fire;

  function automatic logic hit(input logic [exec_pkg::OP_W-1:0] code);
    hit = take && (op_code == code);
  endfunction

  // decode is ignored while the call's second cycle runs
  assign take    = op_valid && !busy;
  assign is_call = hit(exec_pkg::OP_CALL);
  assign is_byte = hit(exec_pkg::OP_BYTECL);
  assign is_bit  = hit(exec_pkg::OP_BITCL);
  assign is_wd   = hit(exec_pkg::OP_WDCLR);
  assign is_wd1  = hit(exec_pkg::OP_WDCLR1);
  assign is_wd2  = hit(exec_pkg::OP_WDCLR2);

  paired_clear_tracker u_pair (
    .ref_clk                      (ref_clk),
    .rstn                         (rstn),
    .first_paired_watchdog_clear  (is_wd1),
    .second_paired_watchdog_clear (is_wd2),
    .pair_fire                    (pair_fire)
  );

  assign wd_fire = is_wd || pair_fire;

  // ---------------------------------------------------------------
  // call sequencing and memory write
  // ---------------------------------------------------------------
  logic                        next_busy;
  logic                        next_stack_push;
  logic [exec_pkg::PC_W-1:0]   next_stack_data;
  logic                        next_pc_load;
  logic [exec_pkg::PC_W-1:0]   next_pc_value;
  logic                        next_mem_we;
  logic [exec_pkg::ADDR_W-1:0] next_mem_waddr;
  logic [exec_pkg::DATA_W-1:0] next_mem_wdata;

  always_comb begin
    next_busy       = 1'b0;
    next_stack_push = 1'b0;
    next_stack_data = stack_data;
    next_pc_load    = 1'b0;
    next_pc_value   = pc_value;
    next_mem_we     = 1'b0;
    next_mem_waddr  = mem_waddr;
    next_mem_wdata  = mem_wdata;
    if (is_call) begin
      // push return address first, jump lands in the second cycle
      next_stack_push = 1'b1;
      next_stack_data = cur_pc + exec_pkg::PC_STEP;
      next_busy       = 1'b1;
      next_pc_value   = call_target;
    end
    if (busy) begin
      next_pc_load = 1'b1;
    end
    if (is_byte) begin
      next_mem_we    = 1'b1;
      next_mem_waddr = mem_addr;
      next_mem_wdata = exec_pkg::BYTE_CLEARED;
    end else if (is_bit) begin
      next_mem_we    = 1'b1;
      next_mem_waddr = mem_addr;
      next_mem_wdata = mem_rdata & ~(8'h01 << bit_sel);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy       <= 1'b0;
      stack_push <= 1'b0;
      stack_data <= exec_pkg::PC_RESET;
      pc_load    <= 1'b0;
      pc_value   <= exec_pkg::PC_RESET;
      mem_we     <= 1'b0;
      mem_waddr  <= '0;
      mem_wdata  <= exec_pkg::BYTE_CLEARED;
    end else begin
      busy       <= next_busy;
      stack_push <= next_stack_push;
      stack_data <= next_stack_data;
      pc_load    <= next_pc_load;
      pc_value   <= next_pc_value;
      mem_we     <= next_mem_we;
      mem_waddr  <= next_mem_waddr;
      mem_wdata  <= next_mem_wdata;
    end
  end

  // ---------------------------------------------------------------
  // watchdog clear and status flags
  // ---------------------------------------------------------------
  // memory clears and calls never reach these flags
  logic next_wd_clear;
  logic next_timeout;
  logic next_powerdown;

  always_comb begin
    next_wd_clear  = wd_fire;
    next_timeout   = timeout_flag;
    next_powerdown = powerdown_flag;
    if (wd_fire) begin
      next_timeout   = exec_pkg::FLAG_RESET;
      next_powerdown = exec_pkg::FLAG_RESET;
    end
    // a hardware event in the clearing cycle is not lost
    if (timeout_set) begin
      next_timeout = 1'b1;
    end
    if (powerdown_set) begin
      next_powerdown = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_counter_clear <= 1'b0;
      timeout_flag           <= exec_pkg::FLAG_RESET;
      powerdown_flag         <= exec_pkg::FLAG_RESET;
    end else begin
      watchdog_counter_clear <= next_wd_clear;
      timeout_flag           <= next_timeout;
      powerdown_flag         <= next_powerdown;
    end
  end
endmodule

// ==== tb/dmem_model.sv ====
// Purpose: data memory beside the exec block
// Assumes: read data follows the address in the same cycle
// Notes:   contents start from a fixed pattern, not zero
`timescale 1ns/1ps
module dmem_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] mem_addr,
  output logic      [7:0] mem_rdata,
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_waddr,
  input  wire logic [7:0] mem_wdata
);
  logic [7:0] mem [256];
  // a nonzero start makes byte and bit clears visible
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
  assign mem_rdata = mem[mem_addr];
  always @(posedge ref_clk) if (mem_we) mem[mem_waddr] <= mem_wdata;
endmodule

// ==== tb/cw_sva.sv ====
// Purpose: port checks for call_clear_watchdog_exec
// Assumes: exec_pkg command codes
// Notes:   pair history is rebuilt here
`timescale 1ns/1ps
module cw_sva (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        op_valid,
  input wire logic [2:0]  op_code,
  input wire logic [10:0] cur_pc,
  input wire logic [10:0] call_target,
  input wire logic [2:0]  bit_sel,
  input wire logic [7:0]  mem_rdata,
  input wire logic        timeout_set,
  input wire logic        powerdown_set,
  input wire logic        busy,
  input wire logic        stack_push,
  input wire logic [10:0] stack_data,
  input wire logic        pc_load,
  input wire logic [10:0] pc_value,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_wdata,
  input wire logic        watchdog_counter_clear,
  input wire logic        timeout_flag,
  input wire logic        powerdown_flag
);
  // ----------------
  // helper
  // ----------------
  logic [1:0] last;
  wire take  = op_valid && !busy;
  wire quiet = !timeout_set && !powerdown_set;
  wire cl    = take && op_code == exec_pkg::OP_CALL;
  wire bc    = take && op_code == exec_pkg::OP_BYTECL;
  wire kc    = take && op_code == exec_pkg::OP_BITCL;
  wire wc    = take && op_code == exec_pkg::OP_WDCLR;
  wire w1    = take && op_code == exec_pkg::OP_WDCLR1;
  wire w2    = take && op_code == exec_pkg::OP_WDCLR2;
  wire alt   = (w1 && last == 2'h2) || (w2 && last == 2'h1);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // single clear leaves the history as it was
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) last <= 2'h0;
    else if (w1) last <= 2'h1;
    else if (w2) last <= 2'h2;
  property p_push; cl |=> stack_push && stack_data == $past(cur_pc) + 11'h001; endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_load; cl |=> ##1 pc_load && pc_value == $past(call_target, 2); endproperty
  a_load: assert property (p_load) else $error("load wrong");
  property p_two; cl |=> busy ##1 !busy; endproperty
  a_two: assert property (p_two) else $error("call length");
  property p_byte; bc |=> mem_we && mem_wdata == 8'h00; endproperty
  a_byte: assert property (p_byte) else $error("byte clear");
  property p_bit; kc |=> mem_wdata == ($past(mem_rdata) & ~(8'h01 << $past(bit_sel))); endproperty
  a_bit: assert property (p_bit) else $error("bit clear");
  property p_wd; wc && quiet |=> watchdog_counter_clear && !timeout_flag && !powerdown_flag; endproperty
  a_wd: assert property (p_wd) else $error("single clear");
  property p_alt; alt && quiet |=> watchdog_counter_clear && !timeout_flag; endproperty
  a_alt: assert property (p_alt) else $error("paired clear");
  property p_rep; (w1 || w2) && !alt |=> !watchdog_counter_clear; endproperty
  a_rep: assert property (p_rep) else $error("repeat clear");
  property p_keep; !wc && !alt && quiet |=> $stable(timeout_flag) && $stable(powerdown_flag); endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
endmodule
bind call_clear_watchdog_exec cw_sva i_cw_sva (.*);

// ==== tb/tb_call_clear_watchdog_exec.sv ====
// Purpose: self-checking bench for call_clear_watchdog_exec
// Assumes: results come back in command order
// Notes:   a queue pairs each result with its note
`timescale 1ns/1ps
module tb_call_clear_watchdog_exec;
  logic        ref_clk = 1'b0, rstn = 1'b0, op_valid = 1'b0;
  logic        timeout_set = 1'b0, powerdown_set = 1'b0;
  logic [2:0]  op_code = 3'h0, bit_sel = 3'h0;
  logic [10:0] cur_pc = 11'h000, call_target = 11'h000, stack_data, pc_value;
  logic [7:0]  mem_addr = 8'h00, mem_rdata, mem_waddr, mem_wdata;
  logic        busy, stack_push, pc_load, mem_we, watchdog_counter_clear;
  logic        timeout_flag, powerdown_flag;
  logic [31:0] seed = 32'h480c;
  logic [23:0] q[$];
  int          n_mismatch = 0, compares = 0;
  call_clear_watchdog_exec i_call_clear_watchdog_exec (.*);
  dmem_model i_dmem_model (.*);
  always #10 ref_clk = ~ref_clk;
  // ----------------
  // tasks
  // ----------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD result exp %h got %h", e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      op_valid <= 1'b0;
    end
  endtask
  task automatic setf();
    @(posedge ref_clk);
    op_valid <= 1'b0;
    timeout_set <= 1'b1;
    powerdown_set <= 1'b1;
    @(posedge ref_clk);
    timeout_set <= 1'b0;
    powerdown_set <= 1'b0;
    @(negedge ref_clk);
    chk(24'h3, {22'h0, timeout_flag, powerdown_flag});
  endtask
  // f low: the command must leave no result
  task automatic cmd(input logic [2:0] op, input logic f, input logic [2:0] b = 3'h0);
    logic [7:0] a;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    a = seed[31:24];
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= op;
    cur_pc <= seed[10:0];
    call_target <= seed[21:11];
    mem_addr <= a;
    bit_sel <= b;
    if (f) case (op)
      exec_pkg::OP_CALL: begin
        q.push_back({4'h1, 9'h0, seed[10:0] + 11'h001});
        q.push_back({4'h2, 9'h0, seed[21:11]});
      end
      exec_pkg::OP_BYTECL: q.push_back({4'h3, 4'h0, a, 8'h00});
      exec_pkg::OP_BITCL: q.push_back({4'h3, 4'h0, a, i_dmem_model.mem[a] & ~(8'h01 << b)});
      default: q.push_back({4'h4, 20'h0});
    endcase
  endtask
  always @(negedge ref_clk) begin
    if (stack_push === 1'b1) chk(q.pop_front(), {4'h1, 9'h0, stack_data});
    if (pc_load === 1'b1) chk(q.pop_front(), {4'h2, 9'h0, pc_value});
    if (mem_we === 1'b1) chk(q.pop_front(), {4'h3, 4'h0, mem_waddr, mem_wdata});
    if (watchdog_counter_clear === 1'b1)
      chk(q.pop_front(), {4'h4, 18'h0, timeout_flag, powerdown_flag});
  end
  initial begin
    #40000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    cmd(exec_pkg::OP_CALL, 1'b1);
    cmd(exec_pkg::OP_BYTECL, 1'b0);
    idle(1);
    cmd(exec_pkg::OP_CALL, 1'b1);
    idle(2);
    for (int i = 0; i < 16; i++) begin
      cmd(i[0] ? exec_pkg::OP_BITCL : exec_pkg::OP_BYTECL, 1'b1, i[3:1]);
      idle(2);
    end
    setf();
    cmd(exec_pkg::OP_WDCLR1, 1'b0);
    cmd(exec_pkg::OP_WDCLR1, 1'b0);
    cmd(exec_pkg::OP_WDCLR2, 1'b1);
    setf();
    cmd(exec_pkg::OP_WDCLR2, 1'b0);
    cmd(exec_pkg::OP_WDCLR1, 1'b1);
    setf();
    cmd(exec_pkg::OP_WDCLR, 1'b1);
    cmd(exec_pkg::OP_WDCLR2, 1'b1);
    setf();
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(posedge ref_clk);
    rstn <= 1'b1;
    cmd(exec_pkg::OP_WDCLR2, 1'b0);
    idle(4);
    @(negedge ref_clk);
    chk(24'h0, {22'h0, timeout_flag, powerdown_flag});
    chk(24'h0, 24'(q.size()));
    end_sim();
  end
endmodule
